/* File: core/lsd_core.sv */
`timescale 1ns/100ps
module lsd_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire lsd_pkg::lsd_pins_type pins,
	input wire lsd_pkg::lsd_sense_type sense,
	output logic [15:0] sink_channels,
	output logic serial_out,
	output logic shift_clock_out,
	output logic alarm_out,
	output logic alarm_oe
);

	lsd_pkg::lsd_state_type state_q;
	logic [15:0] shift_q;
	logic [15:0] latch_q;
	logic [15:0] sink_q;
	logic [15:0] fault_q;
	logic [15:0] fault_new;
	logic [15:0] sensed;
	logic [15:0] qual;
	logic sclk_q;
	logic strobe_q;
	logic select_q;
	logic temp_q;
	logic serial_out_q;
	logic alarm_oe_q;
	logic alarm_en_q;
	logic [2:0] probe_cnt_q;
	logic [3:0] int_stat_q;
	logic [3:0] int_mask_q;
	logic [3:0] int_set;
	logic [3:0] int_clr;
	logic [31:0] rdata_d;
	logic [31:0] prdata_q;
	logic err_d;
	logic err_q;
	logic ready_q;
	logic acc;
	logic clk_rise;
	logic clk_fall;
	logic strobe_rise;
	logic select_edge;
	logic smart_req;
	logic start_probe;
	logic load_fault;
	logic out_step;
	logic probing;

	// pin edge detection, inputs are synchronous to pclk
	assign clk_rise = pins.serial_clk & ~sclk_q;
	assign clk_fall = ~pins.serial_clk & sclk_q;
	assign strobe_rise = pins.latch_strobe & ~strobe_q;
	assign select_edge = pins.detect_select ^ select_q;
	assign probing = (state_q == lsd_pkg::ST_PROBE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			strobe_q <= 1'b0;
			select_q <= 1'b0;
			temp_q <= 1'b0;
			shift_clock_out <= 1'b0;
		end else if (ce) begin
			sclk_q <= pins.serial_clk;
			strobe_q <= pins.latch_strobe;
			select_q <= pins.detect_select;
			temp_q <= sense.over_temp;
			shift_clock_out <= pins.serial_clk;
		end
	end

	// apb slave, no wait state after setup
	assign acc = psel & penable & pready;
	assign pready = penable & ready_q & ce;
	assign pslverr = pready & err_q;
	assign prdata = prdata_q;

	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if (paddr == lsd_pkg::ADDR_CTRL) begin
			rdata_d[lsd_pkg::CTRL_ALARM_EN_BIT] = alarm_en_q;
			rdata_d[lsd_pkg::CTRL_SMART_BIT] = ~(state_q == lsd_pkg::ST_IDLE);
		end else if (paddr == lsd_pkg::ADDR_LATCH) begin
			rdata_d[15:0] = latch_q;
		end else if (paddr == lsd_pkg::ADDR_FAULT) begin
			rdata_d[15:0] = fault_q;
			rdata_d[lsd_pkg::FAULT_TEMP_BIT] = sense.over_temp;
			rdata_d[lsd_pkg::FAULT_BUSY_BIT] = ~(state_q == lsd_pkg::ST_IDLE);
			rdata_d[lsd_pkg::FAULT_SHORT_MODE_BIT] = pins.detect_select;
		end else if (paddr == lsd_pkg::ADDR_INT_STAT) begin
			rdata_d[3:0] = int_stat_q;
		end else if (paddr == lsd_pkg::ADDR_INT_MASK) begin
			rdata_d[3:0] = int_mask_q;
		end else begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (ce) begin
			ready_q <= psel & ~acc;
			if (psel && !acc) begin
				prdata_q <= rdata_d;
				err_q <= err_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_en_q <= lsd_pkg::CTRL_ALARM_EN_RESET;
			int_mask_q <= lsd_pkg::INT_MASK_RESET;
		end else if (ce && acc && pwrite) begin
			if (paddr == lsd_pkg::ADDR_CTRL) begin
				alarm_en_q <= pwdata[lsd_pkg::CTRL_ALARM_EN_BIT];
			end else if (paddr == lsd_pkg::ADDR_INT_MASK) begin
				int_mask_q <= pwdata[3:0];
			end
		end
	end

	assign smart_req = acc & pwrite & (paddr == lsd_pkg::ADDR_CTRL)
		& pwdata[lsd_pkg::CTRL_SMART_BIT];

	// sticky events; a read clears only what it returned
	always_comb begin
		int_set = 4'h0;
		int_set[lsd_pkg::INT_FAULT_BIT] = |fault_new;
		int_set[lsd_pkg::INT_THERMAL_BIT] = sense.over_temp & ~temp_q;
		int_set[lsd_pkg::INT_SMART_DONE_BIT] = (state_q == lsd_pkg::ST_LOAD);
		int_set[lsd_pkg::INT_LATCH_BIT] = strobe_rise;
	end

	assign int_clr = (acc && !pwrite && paddr == lsd_pkg::ADDR_INT_STAT) ?
		prdata_q[3:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= lsd_pkg::INT_STAT_RESET;
		end else if (ce) begin
			int_stat_q <= (int_stat_q & ~int_clr) | int_set;
		end
	end

	assign irq = |(int_stat_q & int_mask_q);

	// shift register: fault load wins over a shift
	assign load_fault = strobe_rise | (state_q == lsd_pkg::ST_LOAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= 16'h0000;
		end else if (ce) begin
			if (load_fault) begin
				shift_q <= fault_q;
			end else if (clk_rise) begin
				shift_q <= {shift_q[14:0], pins.serial_in};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= 16'h0000;
		end else if (ce && strobe_rise) begin
			latch_q <= shift_q;
		end
	end

	// serial output on the selected edge of the forwarded clock
	assign out_step = pins.out_edge_select ? clk_fall : clk_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_q <= 1'b0;
		end else if (ce && out_step) begin
			serial_out_q <= shift_q[15];
		end
	end

	assign serial_out = serial_out_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sink_q <= 16'h0000;
		end else if (ce) begin
			if (probing) begin
				sink_q <= 16'hffff;
			end else if (pins.out_enable_n) begin
				sink_q <= 16'h0000;
			end else begin
				sink_q <= latch_q;
			end
		end
	end

	assign sink_channels = sink_q;

	// smart detection sequencer
	assign start_probe = (state_q == lsd_pkg::ST_IDLE) & (select_edge | smart_req);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= lsd_pkg::ST_IDLE;
			probe_cnt_q <= 3'h0;
		end else if (ce) begin
			case (state_q)
				lsd_pkg::ST_IDLE: begin
					probe_cnt_q <= 3'h0;
					if (start_probe) begin
						state_q <= lsd_pkg::ST_PROBE;
					end
				end
				lsd_pkg::ST_PROBE: begin
					probe_cnt_q <= probe_cnt_q + 3'h1;
					if (probe_cnt_q == lsd_pkg::PROBE_LAST) begin
						state_q <= lsd_pkg::ST_LOAD;
					end
				end
				lsd_pkg::ST_LOAD: begin
					state_q <= lsd_pkg::ST_IDLE;
				end
				default: begin
					state_q <= lsd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// per channel fault qualification
	for (genvar i = 0; i < lsd_pkg::CHANNELS; i++) begin : g_chan
		logic [1:0] cnt_q;

		assign sensed[i] = sink_q[i] & (probing ? (sense.open_det[i] | sense.short_det[i]) :
			(pins.detect_select ? sense.short_det[i] : sense.open_det[i]));
		assign qual[i] = sensed[i] & (cnt_q == lsd_pkg::DETECT_CNT_LAST);
		assign fault_new[i] = qual[i] & ~fault_q[i];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q <= 2'h0;
				fault_q[i] <= 1'b0;
			end else if (ce) begin
				if (start_probe || !sensed[i]) begin
					cnt_q <= 2'h0;
				end else if (cnt_q != lsd_pkg::DETECT_CNT_LAST) begin
					cnt_q <= cnt_q + 2'h1;
				end
				if (start_probe) begin
					fault_q[i] <= 1'b0;
				end else if (qual[i]) begin
					fault_q[i] <= 1'b1;
				end else if (sink_q[i] && !sensed[i]) begin
					fault_q[i] <= 1'b0;
				end
			end
		end
	end

	// open-drain alarm: enable high while pulling low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_oe_q <= 1'b0;
		end else if (ce) begin
			alarm_oe_q <= alarm_en_q & ((|fault_q) | sense.over_temp);
		end
	end

	assign alarm_oe = alarm_oe_q;
	assign alarm_out = 1'b0;

	latch_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && strobe_rise |=> latch_q == $past(shift_q))
		else $error("latch did not copy shift register");

	latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(ce && strobe_rise) |=> $stable(latch_q))
		else $error("latch changed without strobe");

	shift_in_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && clk_rise && !load_fault |=>
		shift_q == {$past(shift_q[14:0]), $past(pins.serial_in)})
		else $error("serial input not shifted");

	sink_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && pins.out_enable_n && !probing |=> sink_channels == 16'h0000)
		else $error("outputs on while disabled");

	sink_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !pins.out_enable_n && !probing |=> sink_channels == $past(latch_q))
		else $error("outputs differ from latch");

	out_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && (pins.out_edge_select ? clk_fall : clk_rise) |=>
		serial_out == $past(shift_q[15]))
		else $error("serial output not on selected edge");

	alarm_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && alarm_en_q && ((|fault_q) || sense.over_temp) |=> alarm_oe && !alarm_out)
		else $error("alarm not pulled low on fault");

	fault_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(fault_q[0]) && $past(ce, 1) && $past(ce, 2) && $past(ce, 3) |->
		$past(sensed[0], 1) && $past(sensed[0], 2) && $past(sensed[0], 3))
		else $error("fault flagged before response time");

	smart_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && state_q == lsd_pkg::ST_IDLE && select_edge |=>
		state_q == lsd_pkg::ST_PROBE ##1 sink_channels == 16'hffff)
		else $error("select edge did not start smart test");

	fault_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && state_q == lsd_pkg::ST_LOAD |=> shift_q == $past(fault_q))
		else $error("fault vector not loaded for output");

endmodule

/* File: core/lsd_pkg.sv */
package lsd_pkg;
	localparam int CHANNELS = 16;
	localparam int CLK_PERIOD_NS = 40;
	localparam int DETECT_TIME_NS = 100;
	// least time: round up to whole cycles
	localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] DETECT_CNT_LAST = 2'(DETECT_CYCLES - 1);
	localparam logic [2:0] PROBE_LAST = 3'(DETECT_CYCLES + 1);

	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LATCH = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
	localparam logic [7:0] ADDR_INT_MASK = 8'h10;

	localparam int CTRL_SMART_BIT = 0;
	localparam int CTRL_ALARM_EN_BIT = 1;
	localparam logic CTRL_ALARM_EN_RESET = 1'b1;

	localparam int FAULT_TEMP_BIT = 16;
	localparam int FAULT_BUSY_BIT = 17;
	localparam int FAULT_SHORT_MODE_BIT = 18;

	localparam int INT_W = 4;
	localparam int INT_FAULT_BIT = 0;
	localparam int INT_THERMAL_BIT = 1;
	localparam int INT_SMART_DONE_BIT = 2;
	localparam int INT_LATCH_BIT = 3;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;
	localparam logic [3:0] INT_STAT_RESET = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PROBE = 3'b010,
		ST_LOAD = 3'b100
	} lsd_state_type;

	typedef struct packed {
		logic serial_clk;
		logic serial_in;
		logic latch_strobe;
		logic out_enable_n;
		logic detect_select;
		logic out_edge_select;
	} lsd_pins_type;

	typedef struct packed {
		logic [CHANNELS-1:0] open_det;
		logic [CHANNELS-1:0] short_det;
		logic over_temp;
	} lsd_sense_type;
endpackage

/* File: verification/led_sink_shift_latch_fault_detect_tb.sv */
`timescale 1ns/100ps
module led_sink_shift_latch_fault_detect_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] sink_channels, lo;
	logic serial_out, shift_clock_out, alarm_out, alarm_oe, sclk, sin, strobe;
	logic en_n, det_sel, edge_sel, ce, sclk_prev;
	lsd_pkg::lsd_sense_type sense;
	int failures, compares, cycles, k;

	lsd_core lsd_core_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.pins({sclk, sin, strobe, en_n, det_sel, edge_sel}), .sense(sense),
		.sink_channels(sink_channels), .serial_out(serial_out),
		.shift_clock_out(shift_clock_out), .alarm_out(alarm_out), .alarm_oe(alarm_oe));
	lsd_ctrl_model lsd_ctrl_model_inst (.pclk(pclk), .serial_out(serial_out),
		.serial_clk(sclk), .serial_in(sin), .latch_strobe(strobe));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (presetn === 1'b1) begin
			chk(shift_clock_out, sclk_prev);
		end
		sclk_prev = sclk;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic wait_alarm(input logic v);
		k = 0;
		while (alarm_oe !== v && k < 20) begin
			@(posedge pclk);
			k++;
		end
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, en_n, det_sel, edge_sel} = 6'h00;
		ce = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		sense = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(lsd_pkg::ADDR_CTRL, 32'h00000002);
		rdchk(lsd_pkg::ADDR_INT_MASK, 32'h0);
		rdchk(8'h14, 32'h0);
		chk(err, 1'b1);
		chk(sink_channels, 16'h0000);
		$display("test reset done");
		lsd_ctrl_model_inst.shift_word(16'ha5c3, lo);
		lsd_ctrl_model_inst.strobe();
		repeat (3) @(posedge pclk);
		chk(sink_channels, 16'ha5c3);
		lsd_ctrl_model_inst.shift_word(16'h1234, lo);
		chk(lo, 16'h0000);
		chk(sink_channels, 16'ha5c3);
		en_n <= 1'b1;
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(sink_channels, 16'ha5c3);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(sink_channels, 16'h0000);
		en_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(sink_channels, 16'ha5c3);
		rdchk(lsd_pkg::ADDR_LATCH, 32'h0000a5c3);
		chk(err, 1'b0);
		lsd_ctrl_model_inst.shift_word(16'h0f0f, lo);
		chk(lo, 16'h1234);
		edge_sel <= 1'b1;
		lsd_ctrl_model_inst.shift_word(16'h8001, lo);
		chk(lo, 16'h1e1f);
		edge_sel <= 1'b0;
		$display("test shift and latch done");
		// two-cycle glitch must not count as a fault
		sense.open_det[0] <= 1'b1;
		repeat (2) @(posedge pclk);
		sense.open_det[0] <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(alarm_oe, 1'b0);
		sense.open_det[0] <= 1'b1;
		wait_alarm(1'b1);
		chk(k >= 3 && k < 20, 1'b1);
		rdchk(lsd_pkg::ADDR_FAULT, 32'h00000001);
		apb(1'b1, lsd_pkg::ADDR_INT_MASK, 32'h1);
		@(posedge pclk);
		chk(irq, 1'b1);
		rdchk(lsd_pkg::ADDR_INT_STAT, 32'h9);
		@(posedge pclk);
		chk(irq, 1'b0);
		sense.open_det[0] <= 1'b0;
		wait_alarm(1'b0);
		chk(alarm_oe, 1'b0);
		sense.over_temp <= 1'b1;
		wait_alarm(1'b1);
		chk(alarm_oe, 1'b1);
		chk(alarm_out, 1'b0);
		sense.over_temp <= 1'b0;
		$display("test real-time detection done");
		sense.short_det[5] <= 1'b1;
		det_sel <= 1'b1;
		k = 0;
		while (sink_channels !== 16'hffff && k < 10) begin
			@(posedge pclk);
			k++;
		end
		chk(sink_channels, 16'hffff);
		repeat (12) @(posedge pclk);
		rdchk(lsd_pkg::ADDR_FAULT, 32'h00040020);
		lsd_ctrl_model_inst.shift_word(16'h0000, lo);
		chk(lo, 16'h0020);
		$display("test smart detection done");
		apb(1'b1, lsd_pkg::ADDR_CTRL, 32'h3);
		rdchk(lsd_pkg::ADDR_CTRL, 32'h3);
		repeat (12) @(posedge pclk);
		rdchk(lsd_pkg::ADDR_FAULT, 32'h00040020);
		chk(irq, 1'b1);
		rdchk(lsd_pkg::ADDR_INT_STAT, 32'h7);
		apb(1'b1, lsd_pkg::ADDR_CTRL, 32'h0);
		wait_alarm(1'b0);
		chk(alarm_oe, 1'b0);
		rdchk(lsd_pkg::ADDR_CTRL, 32'h0);
		$display("test register control done");
		wrap_up();
	end
endmodule

/* File: verification/lsd_ctrl_model.sv */
`timescale 1ns/100ps
module lsd_ctrl_model (
	input wire logic pclk,
	input wire logic serial_out,
	output logic serial_clk,
	output logic serial_in,
	output logic latch_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_in = 1'b0;
		latch_strobe = 1'b0;
	end
	// six pclk per serial period, clock parked low between words
	task automatic shift_word(input logic [15:0] d, output logic [15:0] lo);
		for (int i = 15; i >= 0; i--) begin
			@(posedge pclk);
			serial_in <= d[i];
			@(posedge pclk);
			serial_clk <= 1'b1;
			@(posedge pclk);
			@(posedge pclk);
			serial_clk <= 1'b0;
			@(posedge pclk);
			@(posedge pclk);
			lo[i] = serial_out;
		end
		serial_in <= ~d[0];
	endtask
	task automatic strobe();
		@(posedge pclk);
		latch_strobe <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		latch_strobe <= 1'b0;
	endtask
endmodule
